/* pkg/conv_seq_map.vh */
// Constants for the converter sequencer: register fields and timing counts.
// Assumes inclusion by the sequencer top and its pipeline leaf.
`ifndef CONV_SEQ_MAP_VH
`define CONV_SEQ_MAP_VH
`define CORE_PER_CONV      3'd4
`define TICK_PHASE         2'd3
`define WRITE_PHASE        2'd1
`define PIPE_DEPTH         4
`define SAMPLE_WIDTH       12
`define RESULT_WIDTH       16
`define CTRL_START_SRC_BIT 0
`define CTRL_MODE_LO_BIT   3
`define CTRL_MODE_HI_BIT   4
`define CTRL_RESET         5'h00
`define STAT_XTRA_OTR_BIT  4
`define STAT_RESET         5'h00
`define OTR_RESET          8'h00
`define RESULT_RESET       16'h0000
`define MODE_SIMUL         2'h0
`define MODE_SEQUENTIAL    2'h1
`define MODE_OFFSET_CAL    2'h2
`define MODE_GAIN_CAL      2'h3
`define CONV_LIMIT_CORE    49
`endif

/* hw/conv_pipe.v */
// Four-stage converter pipeline with channel tags; shifts on the
// converter-clock enable. Assumes one core clock and async active-low reset.
`timescale 1ns/1ps
`include "conv_seq_map.vh"
module conv_pipe #(
  parameter DEPTH = `PIPE_DEPTH
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rstn,
  // Stage one entry
  input  wire        step,
  input  wire        in_valid,
  input  wire [3:0]  in_tag,
  input  wire [11:0] in_code,
  input  wire        in_otr,
  // Pipeline exit
  output wire        out_valid,
  output wire [3:0]  out_tag,
  output wire [11:0] out_code,
  output wire        out_otr
);
  reg [DEPTH-1:0] vld_r;
  reg [3:0]       tag_r  [0:DEPTH-1];
  reg [11:0]      code_r [0:DEPTH-1];
  reg [DEPTH-1:0] otr_r;
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : stage
      wire        v_in;
      wire [3:0]  t_in;
      wire [11:0] c_in;
      wire        o_in;
      // Stage zero takes the entry port, so no index below zero is built
      if (i == 0) begin : head
        assign v_in = in_valid;
        assign t_in = in_tag;
        assign c_in = in_code;
        assign o_in = in_otr;
      end else begin : body
        assign v_in = vld_r[i-1];
        assign t_in = tag_r[i-1];
        assign c_in = code_r[i-1];
        assign o_in = otr_r[i-1];
      end
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          vld_r[i]  <= 1'b0;
          tag_r[i]  <= 4'h0;
          code_r[i] <= 12'h000;
          otr_r[i]  <= 1'b0;
        end else if (step) begin
          vld_r[i]  <= v_in;
          tag_r[i]  <= t_in;
          code_r[i] <= c_in;
          otr_r[i]  <= o_in;
        end
      end
    end
  endgenerate
  assign out_valid = vld_r[DEPTH-1];
  assign out_tag   = tag_r[DEPTH-1];
  assign out_code  = code_r[DEPTH-1];
  assign out_otr   = otr_r[DEPTH-1];
endmodule // conv_pipe

/* hw/conv_sequencer.v */
// Sequencer for an eight-input two-bank pipelined converter: divider,
// mode control, pair sequencing, result and status registers.
// Assumes the analog core delivers a digitised code per selected input
// (VCORE already quantised) and that the core reads registers directly.
// Function
// - Converter clock is four core clocks
// - Divider fixed, no register changes it
// - Result is 12 bits left-aligned in 16
// - Zero is 0x0000, saturate 0x7FF0 / 0x8000
// - Range flag set outside reference span
// - Eight range flags, bit n for input n
// - Control bits 4:3 select mode
// - Reset selects simultaneous sampling
// - Pairs sampled 0/4, 1/5, 2/6, 3/7
// - Start rising edge samples first pair
// - Pipeline takes three and half converter clocks
// - First of pair enters, partner next
// - Pairs sampled eight core clocks apart
// - Status bit per pair when both valid
// - New sequence clears status register
// - Last result valid raises complete interrupt
// - Start to interrupt within 49 core clocks
// - Control bit 0 picks start source
// - Idle converts input 0 into tracking register
// - Tracking flag in status bit four only
// - Sequential samples four clocks apart, status together
`timescale 1ns/1ps
`include "conv_seq_map.vh"
module conv_sequencer (
  // Clock and reset
  input  wire        CLK,
  input  wire        RSTN,
  // Start sources (asynchronous pins)
  input  wire        PWM_PERIOD_SYNC_PULSE,
  input  wire        EXTERNAL_START_PIN,
  // Control register write port
  input  wire        CTRL_WE,
  input  wire [4:0]  CTRL_WDATA,
  // Analog core: selected input number and its digitised value
  output wire [2:0]  ANALOG_SELECT,
  output wire        ANALOG_SAMPLE,
  input  wire [12:0] ANALOG_CORE_VALUE,
  // Memory-mapped registers
  output wire [4:0]  CONVERTER_CONTROL_REG,
  output wire [4:0]  CONVERSION_STATUS_REG,
  output wire [7:0]  RANGE_FAULT_FLAGS,
  output wire [15:0] TRACKING_RESULT,
  output wire [127:0] CONVERSION_RESULTS,
  // Interrupt request to the interrupt controller unit, and converter clock tick
  output wire        CONVERSION_DONE_IRQ,
  output wire        CONVERTER_CLOCK_TICK
);
  localparam ST_IDLE = 3'b001;
  localparam ST_RUN  = 3'b010;
  localparam ST_DRAIN = 3'b100;

  // Saturating 13-bit signed core value to 12-bit code, range flag
  function [12:0] quantise;
    input [12:0] v;
    begin
      if (!v[12] && v[11])
        quantise = {1'b1, 12'h7FF};
      else if (v[12] && !v[11])
        quantise = {1'b1, 12'h800};
      else
        quantise = {1'b0, v[11:0]};
    end
  endfunction

  // Channel number for slot k of a sequence in a given mode
  function [2:0] slot_channel;
    input [2:0] k;
    input       seq;
    begin
      if (seq)
        slot_channel = k;
      else
        slot_channel = {k[0], k[2:1]};
    end
  endfunction

  reg  [1:0]  div_r;
  reg  [4:0]  ctrl_r;
  reg  [4:0]  stat_r;
  reg  [7:0]  otr_r;
  reg  [15:0] xtra_r;
  reg  [15:0] res_r [0:7];
  reg  [1:0]  pwm_sync_r;
  reg  [1:0]  ext_sync_r;
  reg         start_prev_r;
  reg  [2:0]  state_r;
  reg  [3:0]  slot_r;
  reg         irq_r;
  reg  [2:0]  sel_r;
  wire        tick;
  wire        wb;
  wire        start_lvl;
  wire        start_edge;
  wire        seq_mode;
  wire [12:0] q;
  wire        p_vld;
  wire [3:0]  p_tag;
  wire [11:0] p_code;
  wire        p_otr;
  wire        last_slot;
  wire [3:0]  enter_tag;
  wire [12:0] enter_val;
  wire        enter_vld;
  wire [4:0]  ctrl_nxt;

  // Fixed divide-by-four, no software access to it
  assign tick = (div_r == `TICK_PHASE);
  // Results land half a converter clock after the last stage loads;
  // waiting for the next tick would overrun the start-to-done budget
  assign wb   = (div_r == `WRITE_PHASE);
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN)
      div_r <= 2'd0;
    else
      div_r <= div_r + 2'd1;
  end

  // Only mode and start-source bits are writable
  assign ctrl_nxt = {CTRL_WDATA[4:3], 2'b00, CTRL_WDATA[0]};
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN)
      ctrl_r <= `CTRL_RESET;
    else if (CTRL_WE)
      ctrl_r <= ctrl_nxt;
  end
  assign seq_mode = (ctrl_r[4:3] == `MODE_SEQUENTIAL);

  // Pins cross into the core clock through two flops each
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pwm_sync_r   <= 2'b00;
      ext_sync_r   <= 2'b00;
      start_prev_r <= 1'b0;
    end else begin
      pwm_sync_r   <= {pwm_sync_r[0], PWM_PERIOD_SYNC_PULSE};
      ext_sync_r   <= {ext_sync_r[0], EXTERNAL_START_PIN};
      start_prev_r <= start_lvl;
    end
  end
  assign start_lvl  = ctrl_r[`CTRL_START_SRC_BIT] ? ext_sync_r[1]
                                                  : pwm_sync_r[1];
  assign start_edge = start_lvl && !start_prev_r;

  // Slot counter: one channel entering the pipeline per converter clock
  assign last_slot = (slot_r == 4'd7);
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_r <= ST_IDLE;
      slot_r  <= 4'd0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start_edge) begin
            state_r <= ST_RUN;
            slot_r  <= 4'd0;
          end
        end
        ST_RUN: begin
          if (tick) begin
            if (last_slot)
              state_r <= ST_DRAIN;
            else
              slot_r <= slot_r + 4'd1;
          end
        end
        ST_DRAIN: begin
          if (wb && p_vld && p_tag == 4'hF)
            state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Sample: pairs every second converter clock, or one input per clock
  assign q = quantise(ANALOG_CORE_VALUE);
  // Select lags the slot by one clock, harmless: every capture comes
  // at least one clock after a slot change, and slot 0 is input 0
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN)
      sel_r <= 3'd0;
    else if (state_r == ST_RUN)
      sel_r <= slot_channel(slot_r[2:0], seq_mode);
    else
      sel_r <= 3'd0;
  end

  // Simultaneous: slot 2k holds input k, slot 2k+1 takes its partner
  assign enter_vld = (state_r == ST_RUN) ? 1'b1 : (state_r == ST_IDLE);
  assign enter_tag = (state_r == ST_RUN) ?
                     {1'b1, slot_channel(slot_r[2:0], seq_mode)} : 4'h0;
  assign enter_val = q;

  conv_pipe #(.DEPTH(`PIPE_DEPTH)) u_pipe (
    .clk       (CLK),
    .rstn      (RSTN),
    .step      (tick),
    .in_valid  (enter_vld),
    .in_tag    (enter_tag),
    .in_code   (enter_val[11:0]),
    .in_otr    (enter_val[12]),
    .out_valid (p_vld),
    .out_tag   (p_tag),
    .out_code  (p_code),
    .out_otr   (p_otr)
  );

  // Writeback of results, range flags and status
  integer n;
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      otr_r  <= `OTR_RESET;
      stat_r <= `STAT_RESET;
      xtra_r <= `RESULT_RESET;
      irq_r  <= 1'b0;
      for (n = 0; n < 8; n = n + 1)
        res_r[n] <= `RESULT_RESET;
    end else begin
      irq_r <= 1'b0;
      if (state_r == ST_IDLE && start_edge) begin
        stat_r <= `STAT_RESET;
      end else if (wb && p_vld && p_tag[3]) begin
        res_r[p_tag[2:0]]  <= {p_code, 4'h0};
        otr_r[p_tag[2:0]]  <= p_otr;
        if (!seq_mode && p_tag[2])
          stat_r[p_tag[1:0]] <= 1'b1;
        if (p_tag[2:0] == 3'd7) begin
          if (seq_mode)
            stat_r[3:0] <= 4'hF;
          irq_r <= 1'b1;
        end
      end else if (wb && p_vld && state_r == ST_IDLE) begin
        xtra_r <= {p_code, 4'h0};
        stat_r[`STAT_XTRA_OTR_BIT] <= p_otr;
      end
    end
  end

  assign ANALOG_SELECT         = sel_r;
  assign ANALOG_SAMPLE         = tick;
  assign CONVERTER_CONTROL_REG = ctrl_r;
  assign CONVERSION_STATUS_REG = stat_r;
  assign RANGE_FAULT_FLAGS     = otr_r;
  assign TRACKING_RESULT       = xtra_r;
  assign CONVERSION_DONE_IRQ   = irq_r;
  assign CONVERTER_CLOCK_TICK  = tick;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : res_out
      assign CONVERSION_RESULTS[g*16 +: 16] = res_r[g];
    end
  endgenerate
endmodule // conv_sequencer

/* tb/conv_sequencer_monitor.sv */
// Assertion checker for the converter sequencer, bound to its top ports.
// Assumes one core clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
module conv_sequencer_monitor (
  // Clock and reset
  input wire         CLK,
  input wire         RSTN,
  // Watched outputs
  input wire [4:0]   CONVERTER_CONTROL_REG,
  input wire [4:0]   CONVERSION_STATUS_REG,
  input wire [15:0]  TRACKING_RESULT,
  input wire [127:0] CONVERSION_RESULTS,
  input wire         CONVERSION_DONE_IRQ,
  input wire         CONVERTER_CLOCK_TICK
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  tick_period_a: assert property (
    CONVERTER_CLOCK_TICK |-> ##4 CONVERTER_CLOCK_TICK)
    else $error("tick period");
  tick_gap_a: assert property (
    CONVERTER_CLOCK_TICK |=> !CONVERTER_CLOCK_TICK [*3])
    else $error("tick gap");
  low_nibble_a: assert property (
    TRACKING_RESULT[3:0] == 4'h0 && CONVERSION_RESULTS[115:112] == 4'h0)
    else $error("low bits set");
  irq_pulse_a: assert property (
    CONVERSION_DONE_IRQ |=> !CONVERSION_DONE_IRQ)
    else $error("irq too long");
  irq_status_a: assert property (
    $rose(CONVERSION_DONE_IRQ) |-> ##[0:1] CONVERSION_STATUS_REG[3:0] == 4'hF)
    else $error("status at irq");
  pair_order_a: assert property (
    $rose(CONVERSION_STATUS_REG[3]) |-> CONVERSION_STATUS_REG[2:0] == 3'h7)
    else $error("pair order");
  ctrl_spare_a: assert property (
    CONVERTER_CONTROL_REG[2:1] == 2'h0)
    else $error("spare control bits");
  track_quiet_a: assert property (
    $changed(TRACKING_RESULT) |->
      $stable(CONVERSION_RESULTS) && !CONVERSION_DONE_IRQ)
    else $error("tracking in sequence");
endmodule // conv_sequencer_monitor
bind conv_sequencer conv_sequencer_monitor mon (.CLK(CLK), .RSTN(RSTN),
  .CONVERTER_CONTROL_REG(CONVERTER_CONTROL_REG),
  .CONVERSION_STATUS_REG(CONVERSION_STATUS_REG),
  .TRACKING_RESULT(TRACKING_RESULT), .CONVERSION_RESULTS(CONVERSION_RESULTS),
  .CONVERSION_DONE_IRQ(CONVERSION_DONE_IRQ),
  .CONVERTER_CLOCK_TICK(CONVERTER_CLOCK_TICK));

/* tb/analog_core_model.sv */
// Behavioural analog core: digitised difference of the selected input.
// Assumes the bench loads one signed 13-bit value per input.
`timescale 1ns/1ps
module analog_core_model (
  // Selection and input values, input n at bits n*13+12:n*13
  input  wire [2:0]   sel,
  input  wire [103:0] vin,
  // Digitised core difference
  output wire [12:0]  value
);
  assign value = vin[sel*13 +: 13];
endmodule // analog_core_model

/* tb/conv_sequencer_tb.sv */
// Self-checking bench for the converter sequencer.
// Assumes a 10 MHz core clock and the sequencer's own control write port.
`timescale 1ns/1ps
module conv_sequencer_tb;
  typedef struct {logic [1:0] m; logic s; integer v; logic [16:0] e;} row_t;
  // Mode, source, value on one input, expected range flag and result
  row_t rows [5] = '{'{2'h0, 1'b0, 2048, 17'h17FF0},
    '{2'h1, 1'b1, -2049, 17'h18000}, '{2'h2, 1'b0, 2047, 17'h07FF0},
    '{2'h3, 1'b1, -1, 17'h0FFF0}, '{2'h0, 1'b1, -2048, 17'h08000}};
  reg          clk = 1'b0;
  reg          rstn = 1'b0;
  reg          pwm = 1'b0;
  reg          ext = 1'b0;
  reg          we = 1'b0;
  reg  [4:0]   wd = 5'h00;
  reg  [103:0] vin = 104'h0;
  reg  [20:0]  ord;
  reg  [16:0]  e;
  reg  [127:0] held;
  reg          clr;
  wire [2:0]   sel;
  wire         smp;
  wire [12:0]  core;
  wire [4:0]   ctrl;
  wire [4:0]   stat;
  wire [7:0]   range_fault_flag;
  wire [15:0]  trk;
  wire [127:0] res;
  wire         irq;
  wire         tick;
  integer      n_errors = 0;
  integer      samples_checked = 0;
  integer      cyc = 0;
  integer      n_irq = 0;
  integer      r, n, k, x, t;
  conv_sequencer uut (.CLK(clk), .RSTN(rstn), .PWM_PERIOD_SYNC_PULSE(pwm),
    .EXTERNAL_START_PIN(ext), .CTRL_WE(we), .CTRL_WDATA(wd),
    .ANALOG_SELECT(sel), .ANALOG_SAMPLE(smp), .ANALOG_CORE_VALUE(core),
    .CONVERTER_CONTROL_REG(ctrl), .CONVERSION_STATUS_REG(stat),
    .RANGE_FAULT_FLAGS(range_fault_flag), .TRACKING_RESULT(trk),
    .CONVERSION_RESULTS(res), .CONVERSION_DONE_IRQ(irq),
    .CONVERTER_CLOCK_TICK(tick));
  analog_core_model core_model (.sel(sel), .vin(vin), .value(core));
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) n_irq <= n_irq + 1;
    if (cyc == 3000) begin
      n_errors++;
      end_of_test;
    end
  end
  task automatic chk(input bit ok, input string msg);
    samples_checked++;
    if (!ok) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  function automatic [16:0] enc(input integer v);
    if (v > 2047) enc = 17'h17FF0;
    else if (v < -2048) enc = 17'h18000;
    else enc = {1'b0, v[11:0], 4'h0};
  endfunction
  task automatic wr(input [4:0] d);
    @(posedge clk);
    #10 we = 1'b1;
    wd = d;
    @(posedge clk);
    #10 we = 1'b0;
    chk(ctrl === {d[4:3], 2'h0, d[0]}, "control readback");
  endtask
  task automatic run_seq(input [1:0] m, input s);
    repeat (4) @(posedge clk);
    wr({m, 2'h0, s});
    if (s) ext = 1'b1;
    else pwm = 1'b1;
    t = 0;
    ord = 21'h0;
    clr = 1'b0;
    while (irq !== 1'b1 && t < 80) begin
      @(posedge clk);
      #1 t++;
      if (stat === 5'h00) clr = 1'b1;
      if (smp === 1'b1 && sel !== 3'h0) ord = {ord[17:0], sel};
    end
    #9 pwm = 1'b0;
    ext = 1'b0;
    chk(clr, "status not cleared");
    chk(t <= 49, "conversion time");
    chk(stat[3:0] === 4'hF, "pair status");
    chk(ord === (m == 2'h1 ? 21'o1234567 : 21'o4152637), "order");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #10 chk({ctrl, stat, range_fault_flag, trk, res, irq} === '0, "reset");
    rstn = 1'b1;
    for (r = 0; r < 5; r++) begin
      k = r * 3 % 8;
      for (n = 0; n < 8; n++) begin
        x = (n == k) ? rows[r].v : n * 16 - 60;
        vin[n*13 +: 13] = x[12:0];
      end
      run_seq(rows[r].m, rows[r].s);
      for (n = 0; n < 8; n++) begin
        e = (n == k) ? rows[r].e : enc(n * 16 - 60);
        chk({range_fault_flag[n], res[n*16 +: 16]} === e, "result or flag");
      end
      if (range_fault_flag[k] === 1'b1)
        chk(res[k*16+15] === (rows[r].v < 0), "range direction");
    end
    // Counter updates one edge after the pulse
    @(posedge clk);
    #10 chk(n_irq === 5, "irq count");
    // Pin of the unselected source must not start a sequence
    wr(5'h00);
    ext = 1'b1;
    repeat (60) @(posedge clk);
    #10 ext = 1'b0;
    chk(n_irq === 5, "unselected source");
    held = res;
    vin[12:0] = 13'h0800;
    // Tracking path: wait for a tick, four stages and the write phase
    repeat (24) @(posedge clk);
    #10 chk({stat, trk} === {5'h1F, 16'h7FF0}, "tracking over");
    vin[12:0] = 13'h1FFB;
    repeat (24) @(posedge clk);
    #10 chk({stat, trk, res} === {5'h0F, 16'hFFB0, held}, "tracking");
    end_of_test;
  end
endmodule // conv_sequencer_tb
